//--- src/sfc_conv_seq.sv
// conversion timing, chop sequencing and apb register file of the decimation filter
// Notes on behaviour
// - mode bit 11 set selects zero latency; clear selects normal latency when chop is off.
// - zero latency, third order: each output period is 3 x 1024 x rate word.
// - zero latency: a channel change restarts the period count; next result one full period after the write.
// - zero latency: every result gets full settling, so one step spoils one result.
// - rate word 96 with notch select gives 50 and 60 Hz notches.
// - chop swaps input polarity per conversion and averages successive pairs.
// - chop, fourth order: output period is 4 x 1024 x rate word.
// - chop mode settling lasts two output periods.
// - chop channel change resets filter; first result after settling, then each period.
// - chop keeps converting through steps; settled two or three results later.
// - chop fourth order with notch select keeps the same output rate.
// - order3 select 1 uses the third-order filter, else fourth order.
// - normal latency: one result per 1024 x rate word after full settling.
//
// The register offsets and the APB register port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "sfc_regs.svh"
module sfc_conv_seq #(
    parameter int unsigned DEC_RATIO = `SFC_DEC_RATIO,
    parameter int unsigned MCLK_DIV  = `SFC_MCLK_DIV
) (
    input  wire logic                    pclk,
    input  wire logic                    presetn,
    input  wire logic                    psel,
    input  wire logic                    penable,
    input  wire logic                    pwrite,
    input  wire logic [`SFC_ADDR_W-1:0]  paddr,
    input  wire logic [31:0]             pwdata,
    output var  logic [31:0]             prdata,
    output var  logic                    pready,
    output var  logic                    pslverr,
    input  wire logic [`SFC_RES_W-1:0]   conv_raw,
    output var  logic                    conv_strobe,
    output var  logic                    filter_rst,
    output var  logic                    chop_swap,
    output var  logic                    order3_filter_select,
    output var  logic                    notch_60hz_select,
    output var  logic [`SFC_CHAN_W-1:0]  chan_sel,
    output var  logic [`SFC_RES_W-1:0]   result,
    output var  logic                    result_valid
);

    // refuse settings the counters cannot hold
    if (DEC_RATIO < 1 || DEC_RATIO > 4096) begin : g_bad_ratio
        $error("sfc_conv_seq: DEC_RATIO must lie in 1..4096");
    end
    if (MCLK_DIV < 1 || MCLK_DIV > 256) begin : g_bad_div
        $error("sfc_conv_seq: MCLK_DIV must lie in 1..256");
    end

    sfc_pkg::sfc_state_t s_r;
    sfc_pkg::sfc_state_t s_nxt;
    sfc_tmr_if           tmr ();

    logic                wr_acc;
    logic                rd_acc;
    logic                rd_setup;
    logic                restart;
    logic                tick;
    logic                strobe;
    logic signed [24:0]  chop_diff;

    // word-aligned map check, shared by write decode and error answer
    function automatic logic addr_ok(input logic [`SFC_ADDR_W-1:0] a);
        addr_ok = (a == `SFC_OFS_MODE) || (a == `SFC_OFS_CHAN) ||
                  (a == `SFC_OFS_STATUS) || (a == `SFC_OFS_DATA);
    endfunction

    // filter order in effect
    function automatic logic [2:0] order_of(input logic ord3);
        order_of = ord3 ? `SFC_ORDER3 : `SFC_ORDER4;
    endfunction

    // periods the timer must span per conversion
    function automatic logic [2:0] mult_of(input logic ord3, input logic zl, input logic ch);
        if (ch || zl) begin
            mult_of = order_of(ord3);
        end else begin
            mult_of = 3'h1;
        end
    endfunction

    // periods counted up to and including the first result after a restart
    function automatic logic [2:0] settle_of(input logic ord3, input logic zl, input logic ch);
        if (ch) begin
            settle_of = `SFC_CHOP_SETTLE;
        end else if (zl) begin
            settle_of = 3'h1;
        end else begin
            settle_of = order_of(ord3);
        end
    endfunction

    function automatic logic [31:0] mode_word(input sfc_pkg::sfc_state_t s);
        mode_word                                                  = 32'h0000_0000;
        mode_word[`SFC_MODE_FS_LSB +: `SFC_MODE_FS_W]              = s.fs;
        mode_word[`SFC_MODE_ZL_BIT]                                = s.zero_lat;
        mode_word[`SFC_MODE_CHOP_BIT]                              = s.chop;
        mode_word[`SFC_MODE_NOTCH_BIT]                             = s.notch;
        mode_word[`SFC_MODE_ORD3_BIT]                              = s.order3;
        mode_word[`SFC_MODE_EN_BIT]                                = s.enable;
    endfunction

    function automatic logic [31:0] status_word(input sfc_pkg::sfc_state_t s);
        status_word                                = 32'h0000_0000;
        status_word[`SFC_ST_READY_BIT]             = s.ready;
        status_word[`SFC_ST_OVR_BIT]               = s.overrun;
        status_word[`SFC_ST_POL_BIT]               = s.pol;
        status_word[`SFC_ST_BUSY_BIT]              = (s.phase != sfc_pkg::SFC_IDLE);
        status_word[`SFC_ST_RUN_BIT]               = (s.phase == sfc_pkg::SFC_RUN);
        status_word[`SFC_ST_LEFT_LSB +: 3]         = s.left;
    endfunction

    // apb decode; zero wait states, prdata caught in the setup cycle
    assign wr_acc   = psel && penable && pwrite && addr_ok(paddr);
    assign rd_acc   = psel && penable && !pwrite && addr_ok(paddr);
    assign rd_setup = psel && !penable && !pwrite;
    assign pready   = psel && penable;
    assign pslverr  = psel && penable && !addr_ok(paddr);

    // any mode or channel write restarts the sequence
    assign restart  = wr_acc && ((paddr == `SFC_OFS_MODE) || (paddr == `SFC_OFS_CHAN));

    // master clock tick from the bus clock prescaler
    assign tick     = (s_r.pre == 8'(MCLK_DIV - 1));
    // a done left from the old sequence lands in the timer start cycle, one after the restart; drop it
    assign strobe   = tmr.done && !s_r.start && (s_r.phase != sfc_pkg::SFC_IDLE);

    // chopped pair: the inverted half is subtracted so offset cancels
    always_comb begin
        if (s_r.pol) begin
            chop_diff = $signed({s_r.prev_raw[23], s_r.prev_raw}) - $signed({conv_raw[23], conv_raw});
        end else begin
            chop_diff = $signed({conv_raw[23], conv_raw}) - $signed({s_r.prev_raw[23], s_r.prev_raw});
        end
    end

    always_comb begin
        s_nxt           = s_r;
        s_nxt.filt_rst  = 1'b0;
        s_nxt.start     = 1'b0;
        s_nxt.res_valid = 1'b0;
        s_nxt.pre       = tick ? 8'h00 : s_r.pre + 8'h01;

        if (rd_setup) begin
            case (paddr)
                `SFC_OFS_MODE: begin
                    s_nxt.prdata = mode_word(s_r);
                end
                `SFC_OFS_CHAN: begin
                    s_nxt.prdata = {28'h0000000, s_r.chan};
                end
                `SFC_OFS_STATUS: begin
                    s_nxt.prdata = status_word(s_r);
                end
                `SFC_OFS_DATA: begin
                    s_nxt.prdata = {8'h00, s_r.result};
                end
                default: begin
                    s_nxt.prdata = 32'h0000_0000;
                end
            endcase
        end

        // clears first, so a same-cycle event below wins
        if (rd_acc && paddr == `SFC_OFS_DATA) begin
            s_nxt.ready = 1'b0;
        end
        if (rd_acc && paddr == `SFC_OFS_STATUS) begin
            s_nxt.overrun = 1'b0;
        end

        if (wr_acc && paddr == `SFC_OFS_MODE) begin
            s_nxt.fs       = pwdata[`SFC_MODE_FS_LSB +: `SFC_MODE_FS_W];
            s_nxt.zero_lat = pwdata[`SFC_MODE_ZL_BIT];
            s_nxt.chop     = pwdata[`SFC_MODE_CHOP_BIT];
            s_nxt.notch    = pwdata[`SFC_MODE_NOTCH_BIT];
            s_nxt.order3   = pwdata[`SFC_MODE_ORD3_BIT];
            s_nxt.enable   = pwdata[`SFC_MODE_EN_BIT];
        end
        if (wr_acc && paddr == `SFC_OFS_CHAN) begin
            s_nxt.chan = pwdata[`SFC_CHAN_W-1:0];
        end

        if (restart) begin
            // new settings are live next cycle, together with the timer start
            if (s_nxt.enable && s_nxt.fs != 10'h000) begin
                s_nxt.phase     = sfc_pkg::SFC_SETTLE;
                s_nxt.left      = settle_of(s_nxt.order3, s_nxt.zero_lat, s_nxt.chop);
                s_nxt.pol       = 1'b0;
                s_nxt.have_prev = 1'b0;
                s_nxt.filt_rst  = 1'b1;
                s_nxt.start     = 1'b1;
            end else begin
                s_nxt.phase     = sfc_pkg::SFC_IDLE;
                s_nxt.pol       = 1'b0;
                s_nxt.have_prev = 1'b0;
                s_nxt.left      = 3'h0;
            end
        end else if (strobe) begin
            case (s_r.chop)
                1'b1: begin
                    // each period records one polarity, then swaps
                    s_nxt.pol       = ~s_r.pol;
                    s_nxt.prev_raw  = conv_raw;
                    s_nxt.have_prev = 1'b1;
                    if (s_r.left != 3'h0) begin
                        s_nxt.left = s_r.left - 3'h1;
                    end
                    if (s_r.have_prev) begin
                        s_nxt.result    = chop_diff[24:1];
                        s_nxt.res_valid = 1'b1;
                        s_nxt.phase     = sfc_pkg::SFC_RUN;
                    end
                end
                default: begin
                    if (s_r.left > 3'h1) begin
                        s_nxt.left = s_r.left - 3'h1;
                    end else begin
                        // zero latency lands here every period
                        s_nxt.left      = 3'h0;
                        s_nxt.result    = conv_raw;
                        s_nxt.res_valid = 1'b1;
                        s_nxt.phase     = sfc_pkg::SFC_RUN;
                    end
                end
            endcase
        end

        if (s_nxt.res_valid) begin
            // unread result overwritten: flag it, set beats clear
            if (s_r.ready && !(rd_acc && paddr == `SFC_OFS_DATA)) begin
                s_nxt.overrun = 1'b1;
            end
            s_nxt.ready = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r          <= '0;
            s_r.phase    <= sfc_pkg::SFC_IDLE;
            s_r.fs       <= 10'(`SFC_MODE_RST);
            s_r.chan     <= `SFC_CHAN_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    // timer runs only while a sequence is live; mult set by filter order and mode
    assign tmr.start = s_r.start;
    assign tmr.run   = (s_r.phase != sfc_pkg::SFC_IDLE);
    assign tmr.tick  = tick;
    assign tmr.mult  = mult_of(s_r.order3, s_r.zero_lat, s_r.chop);
    assign tmr.fs    = s_r.fs;

    sfc_period_timer #(
        .DEC_RATIO (DEC_RATIO)
    ) u_timer (
        .pclk    (pclk),
        .presetn (presetn),
        .t       (tmr.tmr)
    );

    assign prdata               = s_r.prdata;
    assign conv_strobe          = strobe;
    assign filter_rst           = s_r.filt_rst;
    assign chop_swap            = s_r.pol;
    assign order3_filter_select = s_r.order3;
    assign notch_60hz_select    = s_r.notch;
    assign chan_sel             = s_r.chan;
    assign result               = s_r.result;
    assign result_valid         = s_r.res_valid;

endmodule // sfc_conv_seq
`default_nettype wire

//--- src/sfc_regs.svh
// register offsets, field positions, reset values and timing counts of the conversion sequencer
`ifndef SFC_REGS_SVH
`define SFC_REGS_SVH

`define SFC_ADDR_W          12
`define SFC_OFS_MODE        12'h000
`define SFC_OFS_CHAN        12'h004
`define SFC_OFS_STATUS      12'h008
`define SFC_OFS_DATA        12'h00C

`define SFC_MODE_FS_LSB     0
`define SFC_MODE_FS_W       10
`define SFC_MODE_ZL_BIT     11
`define SFC_MODE_CHOP_BIT   13
`define SFC_MODE_NOTCH_BIT  14
`define SFC_MODE_ORD3_BIT   15
`define SFC_MODE_EN_BIT     16
`define SFC_MODE_RST        32'h0000_0060

`define SFC_CHAN_W          4
`define SFC_CHAN_RST        4'h0

`define SFC_ST_READY_BIT    0
`define SFC_ST_OVR_BIT      1
`define SFC_ST_POL_BIT      2
`define SFC_ST_BUSY_BIT     3
`define SFC_ST_RUN_BIT      4
`define SFC_ST_LEFT_LSB     8

`define SFC_RES_W           24
`define SFC_DEC_RATIO       1024
`define SFC_ORDER4          3'h4
`define SFC_ORDER3          3'h3
`define SFC_CHOP_SETTLE     3'h2
`define SFC_MCLK_DIV        20
`define SFC_TMR_W           26

`endif

//--- src/sfc_pkg.sv
// types shared by the conversion sequencer and its period timer
package sfc_pkg;

    typedef enum logic [1:0] {
        SFC_IDLE,
        SFC_SETTLE,
        SFC_RUN
    } sfc_phase_t;

    typedef struct packed {
        sfc_phase_t    phase;
        logic [9:0]    fs;
        logic          zero_lat;
        logic          chop;
        logic          notch;
        logic          order3;
        logic          enable;
        logic [3:0]    chan;
        logic [7:0]    pre;
        logic          pol;
        logic          have_prev;
        logic [2:0]    left;
        logic [23:0]   prev_raw;
        logic [23:0]   result;
        logic          res_valid;
        logic          ready;
        logic          overrun;
        logic          filt_rst;
        logic          start;
        logic [31:0]   prdata;
    } sfc_state_t;

    typedef struct packed {
        logic          run;
        logic [25:0]   cnt;
        logic          done;
    } sfc_tmr_state_t;

endpackage

//--- src/sfc_tmr_if.sv
// carrier between the sequencer and its period timer
`timescale 1ns/1ps
`default_nettype none
interface sfc_tmr_if;
    logic          start;
    logic          run;
    logic          tick;
    logic [2:0]    mult;
    logic [9:0]    fs;
    logic          done;

    modport ctl (output start, output run, output tick, output mult, output fs, input done);
    modport tmr (input start, input run, input tick, input mult, input fs, output done);
endinterface
`default_nettype wire

//--- src/sfc_period_timer.sv
// counts one output period of mult x ratio x rate word master clock ticks
`timescale 1ns/1ps
`default_nettype none
`include "sfc_regs.svh"
module sfc_period_timer #(
    parameter int unsigned DEC_RATIO = `SFC_DEC_RATIO
) (
    input  wire logic    pclk,
    input  wire logic    presetn,
    sfc_tmr_if.tmr       t
);
    sfc_pkg::sfc_tmr_state_t s_r;
    sfc_pkg::sfc_tmr_state_t s_nxt;
    logic [25:0]             target;

    // mult and rate word are held steady by the sequencer between restarts
    assign target = 26'(t.mult) * 26'(t.fs) * 26'(DEC_RATIO);

    always_comb begin
        s_nxt      = s_r;
        s_nxt.done = 1'b0;
        s_nxt.run  = t.run;
        if (t.start || !t.run) begin
            s_nxt.cnt = '0;
        end else if (t.tick) begin
            if (s_r.cnt == target - 26'h1) begin
                s_nxt.cnt  = '0;
                s_nxt.done = 1'b1;
            end else begin
                s_nxt.cnt = s_r.cnt + 26'h1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign t.done = s_r.done;
endmodule // sfc_period_timer
`default_nettype wire

//--- verif/sfc_conv_checker.sv
// concurrent checks on the conversion sequencer ports
`timescale 1ns/1ps
`default_nettype none
`include "sfc_regs.svh"
module sfc_conv_checker (
    input wire logic                   pclk,
    input wire logic                   presetn,
    input wire logic                   psel,
    input wire logic                   penable,
    input wire logic                   pwrite,
    input wire logic [`SFC_ADDR_W-1:0] paddr,
    input wire logic [31:0]            pwdata,
    input wire logic [31:0]            prdata,
    input wire logic                   pready,
    input wire logic                   pslverr,
    input wire logic [`SFC_RES_W-1:0]  conv_raw,
    input wire logic                   conv_strobe,
    input wire logic                   filter_rst,
    input wire logic                   chop_swap,
    input wire logic                   order3_filter_select,
    input wire logic                   notch_60hz_select,
    input wire logic [`SFC_CHAN_W-1:0] chan_sel,
    input wire logic [`SFC_RES_W-1:0]  result,
    input wire logic                   result_valid
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire logic acc     = psel && penable;
    wire logic bad     = paddr > `SFC_OFS_DATA || paddr[1:0] != 2'h0;
    wire logic wr_mode = acc && pwrite && paddr == `SFC_OFS_MODE;

    apb_ready_a: assert property (acc |-> pready) else $error("pready low in access phase");
    bad_addr_a: assert property (acc && bad |-> pslverr) else $error("no error on unmapped access");
    err_cause_a: assert property (pslverr |-> acc && bad) else $error("error without unmapped access");
    restart_pulse_a: assert property (wr_mode && pwdata[16] && pwdata[9:0] != 10'h000 |=> filter_rst ##1 !filter_rst)
        else $error("no single filter reset after mode write");
    settle_gap_a: assert property (filter_rst |-> !conv_strobe [*4]) else $error("strobe too soon after restart");
    strobe_pulse_a: assert property (conv_strobe |=> !conv_strobe) else $error("strobe longer than one cycle");
    valid_cause_a: assert property (result_valid |-> $past(conv_strobe)) else $error("result without strobe");
    result_hold_a: assert property ($changed(result) |-> result_valid) else $error("result moved silently");
    select_out_a: assert property (wr_mode |=> order3_filter_select == $past(pwdata[15])
        && notch_60hz_select == $past(pwdata[14])) else $error("filter selects not updated");
    chan_out_a: assert property (acc && pwrite && paddr == `SFC_OFS_CHAN |=> chan_sel == $past(pwdata[3:0]))
        else $error("channel select not updated");
    idle_quiet_a: assert property (wr_mode && !pwdata[16] |=> !conv_strobe [*8])
        else $error("strobe while disabled");
endmodule // sfc_conv_checker

bind sfc_conv_seq sfc_conv_checker chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .conv_raw, .conv_strobe, .filter_rst, .chop_swap, .order3_filter_select, .notch_60hz_select, .chan_sel,
    .result, .result_valid);
`default_nettype wire

//--- verif/sinc_filter_conversion_timing_test.sv
// self-checking bench for the conversion sequencer
`timescale 1ns/1ps
`default_nettype none
`include "sfc_regs.svh"
module sinc_filter_conversion_timing_test;
    localparam int         DR = 4;
    localparam logic [7:0] ZL = 8'hCC;
    localparam logic [7:0] CH = 8'hB0;
    localparam logic [7:0] O3 = 8'h66;
    localparam logic [7:0] NT = 8'hC0;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [23:0] conv_raw = 24'h0;
    logic [31:0] prdata;
    logic        pready, pslverr, conv_strobe, filter_rst, chop_swap;
    logic        order3_filter_select, notch_60hz_select, result_valid;
    logic [3:0]  chan_sel;
    logic [23:0] result;
    logic [31:0] q;
    logic        e;
    int          errors = 0;
    int          checked = 0;

    // shortened counts keep the run brief
    sfc_conv_seq #(.DEC_RATIO(DR), .MCLK_DIV(1)) dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .conv_raw, .conv_strobe, .filter_rst, .chop_swap, .order3_filter_select,
        .notch_60hz_select, .chan_sel, .result, .result_valid);

    always #5 pclk = ~pclk;
    // small signed samples avoid overflow ambiguity in the chop average
    always @(posedge pclk) conv_raw <= 24'($signed(21'($urandom)));

    function automatic logic [31:0] mode(input logic [9:0] fs, input logic zl, ch, nt, o3, en);
        return {15'h0, en, o3, nt, ch, 1'h0, zl, 1'h0, fs};
    endfunction

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic conclude;
        $display("comparisons %0d mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic step;
        @(posedge pclk);
        #1;
    endtask

    task automatic wait_valid(output int c);
        c = 0;
        do begin
            step();
            c++;
        end while (result_valid !== 1'b1);
    endtask

    task automatic measure(input int first, input int per, input logic chop);
        int          n;
        int          c;
        logic [23:0] s[$];
        logic [24:0] d;
        logic [23:0] x;
        n = 0;
        #1;
        check(32'(filter_rst), 32'h1, "filter reset on restart");
        do begin
            step();
            if (conv_strobe === 1'b1) begin
                check(32'(chop_swap), 32'(chop && n[0]), "input polarity");
                n++;
                s.push_back(conv_raw);
            end
        end while (result_valid !== 1'b1);
        d = {s[0][23], s[0]} - {s[1][23], s[1]};
        x = chop ? d[24:1] : s[$];
        check(32'(n), 32'(first), "strobes before first result");
        check({8'h00, result}, {8'h00, x}, "result value");
        apb(1'b0, `SFC_OFS_DATA, 32'h0);
        check(q, {8'h00, x}, "data register");
        wait_valid(c);
        wait_valid(c);
        check(32'(c), 32'(per), "output period");
    endtask

    initial begin
        logic [9:0]  fs;
        logic [31:0] w;
        logic [3:0]  ch;
        int          ord, first, per, n;
        void'($urandom(49407));
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, `SFC_OFS_MODE, 32'h0);
        check(q, `SFC_MODE_RST, "mode reset value");
        apb(1'b0, `SFC_OFS_CHAN, 32'h0);
        check(q, 32'h0, "channel reset value");
        apb(1'b0, 12'h010, 32'h0);
        check({q[30:0], e}, 32'h1, "unmapped read");
        apb(1'b1, 12'h006, 32'hFFFF_FFFF);
        check({31'h0, e}, 32'h1, "unaligned write");
        for (int i = 0; i < 8; i++) begin
            fs = (i < 6) ? 10'($urandom_range(8, (CH[i] && O3[i]) ? 6 : 1)) : 10'h060;
            ord = O3[i] ? 3 : 4;
            first = CH[i] ? 2 : (ZL[i] ? 1 : ord);
            per = ((ZL[i] | CH[i]) ? ord : 1) * DR * int'(fs);
            w = mode(fs, ZL[i], CH[i], NT[i], O3[i], 1'b1);
            apb(1'b1, `SFC_OFS_MODE, w);
            measure(first, per, CH[i]);
            ch = 4'($urandom);
            apb(1'b1, `SFC_OFS_CHAN, {28'h0, ch});
            measure(first, per, CH[i]);
            check({28'h0, chan_sel}, {28'h0, ch}, "channel select");
            check({30'h0, order3_filter_select, notch_60hz_select}, {30'h0, O3[i], NT[i]}, "selects");
            apb(1'b0, `SFC_OFS_MODE, 32'h0);
            check(q, w, "mode readback");
        end
        // disabled, then enabled with a zero rate word: both must stay idle
        for (int k = 0; k < 2; k++) begin
            apb(1'b1, `SFC_OFS_MODE, k ? mode(10'h000, 0, 0, 0, 0, 1) : mode(10'h005, 0, 0, 0, 0, 0));
            repeat (2) step();
            n = 0;
            repeat (300) begin
                step();
                n += int'(conv_strobe === 1'b1);
            end
            check(32'(n), 32'h0, "strobes while idle");
        end
        conclude();
    end

    initial begin
        #600000;
        errors++;
        conclude();
    end
endmodule // sinc_filter_conversion_timing_test
`default_nettype wire
